//--- bench/cilt_decoder_sva.sv
// assertion checker for the instruction length and timing decoder
`timescale 1ns/1ns
`include "cilt_regs.vh"
module cilt_decoder_sva #(
  parameter MC_CLKS = 4
) (
  input wire clk,
  input wire rst,
  input wire [7:0] r0_val,
  input wire [7:0] r1_val,
  input wire code_ready_q,
  input wire done_q,
  input wire [15:0] pc_q,
  input wire [7:0] op_q,
  input wire [1:0] len_q,
  input wire [1:0] cycles_q,
  input wire [3:0] form_q,
  input wire [7:0] dir_addr_q,
  input wire dir_is_sfr_q,
  input wire [7:0] bit_byte_q,
  input wire [2:0] bit_idx_q,
  input wire [7:0] ind_addr_q,
  input wire [2:0] reg_idx_q,
  input wire [15:0] target_q
);
  reg [7:0] gap_q; // clocks since the last finish, saturating
  // gap counter, restarted by each finish so stalls only ever lengthen it
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      gap_q <= 8'h00;
    else if (done_q)
      gap_q <= 8'h00;
    else if (gap_q != 8'hFF)
      gap_q <= gap_q + 8'h01;
  end
  done_pulse_a: assert property (@(posedge clk) disable iff (rst)
    done_q |=> !done_q) else $error("finish pulse wider than one cycle");
  ready_back_a: assert property (@(posedge clk) disable iff (rst)
    done_q |-> code_ready_q) else $error("fetch not reopened at finish");
  cycle_floor_a: assert property (@(posedge clk) disable iff (rst)
    done_q |-> gap_q >= MC_CLKS * cycles_q + 2) else $error("instruction finished too early");
  sfr_split_a: assert property (@(posedge clk) disable iff (rst)
    done_q |-> dir_is_sfr_q == (dir_addr_q >= 8'h80)) else $error("direct space split wrong");
  ind_select_a: assert property (@(posedge clk) disable iff (rst)
    done_q && (op_q[7:1] == 7'h73 || op_q[7:1] == 7'h63 || op_q[7:1] == 7'h6B)
    |-> ind_addr_q == (op_q[0] ? $past(r1_val) : $past(r0_val)))
    else $error("indirect address from wrong register");
  reg_field_a: assert property (@(posedge clk) disable iff (rst)
    done_q && op_q[7:3] == 5'h1D |-> reg_idx_q == op_q[2:0] && len_q == 2'h1 && cycles_q == 2'h1)
    else $error("register load decoded wrong");
  ptr_load_a: assert property (@(posedge clk) disable iff (rst)
    done_q && op_q == 8'h90 |-> len_q == 2'h3 && cycles_q == 2'h2)
    else $error("pointer load length or time wrong");
  rel_target_a: assert property (@(posedge clk) disable iff (rst)
    done_q && op_q == 8'h80 |-> target_q == pc_q + {{8{dir_addr_q[7]}}, dir_addr_q})
    else $error("relative target wrong");
  short_target_a: assert property (@(posedge clk) disable iff (rst)
    done_q && op_q[3:0] == 4'h1 |-> target_q == {pc_q[15:11], op_q[7:5], dir_addr_q})
    else $error("short target wrong");
  bit_area_a: assert property (@(posedge clk) disable iff (rst)
    done_q && form_q == `CILT_F_BIT && dir_addr_q < 8'h80
    |-> bit_byte_q == 8'h20 + {4'h0, dir_addr_q[6:3]} && bit_idx_q == dir_addr_q[2:0])
    else $error("bit area mapping wrong");
endmodule // cilt_decoder_sva
bind cilt_decoder cilt_decoder_sva #(.MC_CLKS(MC_CLKS)) cilt_decoder_sva_i (
  .clk(clk), .rst(rst), .r0_val(r0_val), .r1_val(r1_val), .code_ready_q(code_ready_q),
  .done_q(done_q), .pc_q(pc_q), .op_q(op_q), .len_q(len_q), .cycles_q(cycles_q),
  .form_q(form_q), .dir_addr_q(dir_addr_q), .dir_is_sfr_q(dir_is_sfr_q),
  .bit_byte_q(bit_byte_q), .bit_idx_q(bit_idx_q), .ind_addr_q(ind_addr_q),
  .reg_idx_q(reg_idx_q), .target_q(target_q));

//--- bench/cilt_prog_mem.sv
// program memory model that offers instruction bytes to the decoder
`timescale 1ns/1ns
module cilt_prog_mem (
  input wire clk,
  input wire rst,
  input wire slow,
  input wire code_ready_q,
  input wire [15:0] pc_q,
  output reg code_valid,
  output wire [7:0] code_byte
);
  reg [7:0] mem [0:255]; // code image, written by the bench
  reg [7:0] lfsr_q; // pacing pattern for the slow mode
  wire [7:0] cur; // byte at the fetch address
  integer i;
  // unwritten code reads as no-operation, never unknown
  initial
  begin
    for (i = 0; i < 256; i = i + 1)
      mem[i] = 8'h00;
  end
  assign cur = mem[pc_q[7:0]];
  // no offer shows the inverse, so a stale sample cannot match
  assign code_byte = code_valid ? cur : ~cur;
  // offer stays up until taken; slow mode inserts random gaps
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      code_valid <= 1'b0;
      lfsr_q <= 8'h5A;
    end
    else
    begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      if (!code_valid || code_ready_q)
        code_valid <= !slow || lfsr_q[0];
    end
  end
endmodule // cilt_prog_mem

//--- bench/tb.sv
// self-checking bench for the instruction length and timing decoder
`timescale 1ns/1ns
module tb;
  localparam MC = 4; // core clocks per machine cycle
  localparam N = 57; // opcode table size
  typedef struct {
    logic [7:0] op;
    logic [1:0] len;
    logic [1:0] cyc;
    logic unsup;
    logic [15:0] pc;
    logic [15:0] tgt;
    bit ct;
    int gap;
    int xk;
    logic [15:0] xv;
  } cilt_note_t;
  reg clk, rst, stall, slow, bit_val, carry;
  reg [7:0] acc, r0_val, r1_val, opnd_val;
  reg [15:0] data_pointer;
  wire code_valid, code_ready_q, done_q, unsup_q, taken_q, dir_is_sfr_q, bit_ok_q;
  wire clear_bit_q, carry_res_q;
  wire [7:0] code_byte, op_q, dir_addr_q, bit_byte_q, ind_addr_q, acc_res_q, mem_res_q;
  wire [15:0] pc_q, target_q, code_addr_q;
  wire [1:0] len_q, cycles_q;
  wire [3:0] form_q;
  wire [2:0] bit_idx_q, reg_idx_q;
  int errors, n_compared, n_done, gap;
  logic [15:0] addr; // next free code address
  cilt_note_t q[$]; // expected results, oldest first
  // opcode, length, then cycles times two plus the unsupported flag
  logic [15:0] tbl [0:N-1] = '{
    16'hE812, 16'hE522, 16'hE612, 16'h7422, 16'hE712, // accumulator loads
    16'hA824, 16'h8824, 16'h8534, 16'h7534, // register and direct moves
    16'h9034, 16'h9314, 16'h8314, // pointer load, code reads
    16'hE014, 16'hF014, 16'hE215, 16'hE315, 16'hF215, 16'hF315, // external forms
    16'hC812, 16'hC522, 16'hC612, 16'hD612, // exchanges
    16'hC312, 16'hD312, 16'hB312, 16'hC222, 16'hD222, 16'hB222, // carry and bit ops
    16'h8224, 16'hB024, 16'h7224, 16'hA024, 16'hA222, 16'h9224, // bit logic
    16'h4024, 16'h5024, 16'h2034, 16'h3034, 16'h1034, // bit jumps
    16'h1124, 16'h1234, 16'h2214, 16'h3214, // calls and returns
    16'h0124, 16'h0234, 16'h8024, 16'h7314, 16'h6024, 16'h7024, // jumps
    16'hB534, 16'hB434, 16'hB834, 16'hB634, 16'hD824, 16'hD534, // loops
    16'h0012, 16'h2813 // idle and an uncovered opcode
  };
  cilt_decoder #(.MC_CLKS(MC)) cilt_decoder_i (.clk(clk), .rst(rst), .code_valid(code_valid),
    .code_byte(code_byte), .stall(stall), .pc_load(1'b0), .pc_load_val(16'h0000), .acc(acc),
    .data_pointer(data_pointer), .r0_val(r0_val), .r1_val(r1_val), .opnd_val(opnd_val), .bit_val(bit_val),
    .carry(carry), .code_ready_q(code_ready_q), .done_q(done_q), .pc_q(pc_q), .op_q(op_q),
    .len_q(len_q), .cycles_q(cycles_q), .form_q(form_q), .unsup_q(unsup_q),
    .dir_addr_q(dir_addr_q), .dir_is_sfr_q(dir_is_sfr_q), .bit_byte_q(bit_byte_q),
    .bit_idx_q(bit_idx_q), .bit_ok_q(bit_ok_q), .ind_addr_q(ind_addr_q), .reg_idx_q(reg_idx_q),
    .target_q(target_q), .taken_q(taken_q), .code_addr_q(code_addr_q),
    .clear_bit_q(clear_bit_q), .acc_res_q(acc_res_q), .mem_res_q(mem_res_q),
    .carry_res_q(carry_res_q));
  cilt_prog_mem cilt_prog_mem_i (.clk(clk), .rst(rst), .slow(slow), .code_ready_q(code_ready_q),
    .pc_q(pc_q), .code_valid(code_valid), .code_byte(code_byte));
  // clock generator
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chkv(input string nm, input logic [15:0] e, input logic [15:0] s);
  begin
    n_compared++;
    if (s !== e)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  end
  endtask
  task chkf(input string nm, input logic e, input logic s);
  begin
    n_compared++;
    if (s !== e)
    begin
      errors++;
      $display("BAD %s expected %b seen %b", nm, e, s);
    end
  end
  endtask
  task summarize;
  begin
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  // bit addressable: low data area, or a register base off the excluded set
  function automatic logic bitok(input logic [7:0] b);
  begin
    bitok = b < 8'h80 || !((b & 8'hF8) inside {8'h80, 8'hA0, 8'hE8, 8'hF8});
  end
  endfunction
  // place table entry k in code memory and note what it must produce
  task place(input int k, input int g);
    cilt_note_t n;
    logic [7:0] op;
    logic [7:0] b1;
    logic [7:0] b2;
  begin
    op = tbl[k][15:8];
    b1 = 8'($urandom);
    b2 = 8'($urandom);
    n.op = op;
    n.len = tbl[k][5:4];
    n.cyc = tbl[k][2:1];
    n.unsup = tbl[k][0];
    n.gap = g < 0 ? 0 : int'(n.cyc) * MC + 3 + g;
    cilt_prog_mem_i.mem[addr[7:0]] = op;
    cilt_prog_mem_i.mem[addr[7:0] + 8'h01] = b1;
    cilt_prog_mem_i.mem[addr[7:0] + 8'h02] = b2;
    addr = addr + 16'(n.len);
    n.pc = addr;
    n.ct = 1'b1;
    if (op == 8'h02 || op == 8'h12)
      n.tgt = {b1, b2};
    else if (op[3:0] == 4'h1)
      n.tgt = {addr[15:11], op[7:5], b1};
    else if (op == 8'h73)
      n.tgt = {8'h00, acc} + data_pointer;
    else if (op inside {8'h40, 8'h50, 8'h60, 8'h70, 8'h80, 8'hD8})
      n.tgt = addr + {{8{b1[7]}}, b1};
    else if (n.len == 2'h3 && !(op inside {8'h90, 8'h85, 8'h75}))
      n.tgt = addr + {{8{b2[7]}}, b2};
    else
      n.ct = 1'b0;
    case (op)
      8'hC2, 8'hD2, 8'hB2: n.xk = 1;
      8'h10: n.xk = 2;
      8'h40, 8'h50, 8'h80, 8'h02, 8'hD5: n.xk = 3;
      8'hD6: n.xk = 4;
      8'h93, 8'h83: n.xk = 5;
      8'hC3, 8'hD3, 8'hB3, 8'h82, 8'hA2: n.xk = 6;
      8'hD8, 8'h92, 8'hC5: n.xk = 7;
      default: n.xk = 0;
    endcase
    case (op)
      8'hC2, 8'hD2, 8'hB2: n.xv = 16'(bitok(b1));
      8'h10: n.xv = 16'(bit_val);
      8'h40: n.xv = 16'(carry);
      8'h50: n.xv = 16'(!carry);
      8'hD5: n.xv = 16'(opnd_val != 8'h01);
      8'hD6: n.xv = {8'h00, acc[7:4], opnd_val[3:0]};
      8'h93: n.xv = {8'h00, acc} + data_pointer;
      8'h83: n.xv = {8'h00, acc} + addr;
      8'hC3: n.xv = 16'h0000;
      8'hB3: n.xv = 16'(!carry);
      8'h82: n.xv = 16'(carry & bit_val);
      8'hA2: n.xv = 16'(bit_val);
      8'hD8: n.xv = {8'h00, opnd_val - 8'h01};
      8'h92: n.xv = 16'(carry);
      8'hC5: n.xv = {8'h00, acc};
      default: n.xv = 16'h0001;
    endcase
    q.push_back(n);
  end
  endtask
  task wait_done(input int m);
    int t;
  begin
    for (t = 0; t < 5000 && n_done < m; t++)
      @(negedge clk);
    if (n_done < m)
    begin
      errors++;
      $display("BAD finish count expected %0d seen %0d", m, n_done);
      summarize;
    end
  end
  endtask
  // result watcher: each finish takes the oldest note
  always @(posedge clk)
  begin : watch
    cilt_note_t n;
    gap++;
    if (rst)
      gap = 0;
    else if (done_q === 1'b1)
    begin
      n_done++;
      if (q.size() == 0)
      begin
        errors++;
        $display("BAD finish expected none seen %h", op_q);
      end
      else
      begin
        n = q.pop_front();
        chkv("opcode", {8'h00, n.op}, {8'h00, op_q});
        chkv("length", {14'h0000, n.len}, {14'h0000, len_q});
        chkv("cycles", {14'h0000, n.cyc}, {14'h0000, cycles_q});
        chkf("unsupported", n.unsup, unsup_q);
        chkv("next_pc", n.pc, pc_q);
        if (n.ct)
          chkv("target", n.tgt, target_q);
        if (n.gap > 0)
          chkv("finish_gap", 16'(n.gap), 16'(gap));
        case (n.xk)
          1: chkf("bit_ok", n.xv[0], bit_ok_q);
          2: chkf("clear_bit", n.xv[0], clear_bit_q);
          3: chkf("taken", n.xv[0], taken_q);
          4: chkv("acc_res", n.xv, {8'h00, acc_res_q});
          5: chkv("code_addr", n.xv, code_addr_q);
          6: chkf("carry_res", n.xv[0], carry_res_q);
          7: chkv("mem_res", n.xv, {8'h00, mem_res_q});
          default: ;
        endcase
      end
      gap = 0;
    end
  end
  // main sequence: timed pass over the table, then a random slow pass
  initial
  begin : main
    int k;
    void'($urandom(32'h3ECC9792));
    rst = 1'b1;
    stall = 1'b0;
    slow = 1'b0;
    acc = 8'($urandom);
    data_pointer = 16'($urandom);
    r0_val = 8'($urandom);
    r1_val = 8'($urandom);
    opnd_val = 8'($urandom);
    bit_val = 1'b1;
    carry = 1'b0;
    addr = 16'h0000;
    // code goes in only after the model has cleared its image at time zero
    @(posedge clk);
    for (k = 0; k < N; k++)
      place(k, k == 0 ? -1 : (k == 2 ? 3 : 0));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // three stalled clocks inside the third instruction
    wait_done(2);
    @(posedge clk);
    stall <= 1'b1;
    repeat (3) @(posedge clk);
    stall <= 1'b0;
    wait_done(N);
    // second reset mid-run, new operand values, slow memory
    @(posedge clk);
    rst <= 1'b1;
    slow <= 1'b1;
    acc <= 8'($urandom);
    data_pointer <= 16'($urandom);
    opnd_val <= 8'h01;
    bit_val <= 1'b0;
    carry <= 1'b1;
    @(posedge clk);
    addr = 16'h0000;
    for (k = 0; k < 40; k++)
      place($urandom_range(N - 1, 0), -1);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wait_done(N + 40);
    summarize;
  end
endmodule // tb

//--- src/cilt_decoder.v
// instruction length, timing and operand decoder for the transfer groups
`timescale 1ns/1ns
`include "cilt_regs.vh"
module cilt_decoder #(
  parameter MC_CLKS = `CILT_MC_CLKS
) (
  input wire clk,
  input wire rst,
  input wire code_valid,
  input wire [7:0] code_byte,
  input wire stall,
  input wire pc_load,
  input wire [15:0] pc_load_val,
  input wire [7:0] acc,
  input wire [15:0] data_pointer,
  input wire [7:0] r0_val,
  input wire [7:0] r1_val,
  input wire [7:0] opnd_val,
  input wire bit_val,
  input wire carry,
  output reg code_ready_q,
  output reg done_q,
  output reg [15:0] pc_q,
  output reg [7:0] op_q,
  output reg [1:0] len_q,
  output reg [1:0] cycles_q,
  output reg [3:0] form_q,
  output reg unsup_q,
  output reg [7:0] dir_addr_q,
  output reg dir_is_sfr_q,
  output reg [7:0] bit_byte_q,
  output reg [2:0] bit_idx_q,
  output reg bit_ok_q,
  output reg [7:0] ind_addr_q,
  output reg [2:0] reg_idx_q,
  output reg [15:0] target_q,
  output reg taken_q,
  output reg [15:0] code_addr_q,
  output reg clear_bit_q,
  output reg [7:0] acc_res_q,
  output reg [7:0] mem_res_q,
  output reg carry_res_q
);
  // table entry: {unsupported, form, length, cycles}
  function [8:0] optab;
    input [7:0] op;
    begin
      casez (op)
        8'h00: optab = {1'b0, `CILT_F_NONE, `CILT_B1, `CILT_C1};
        8'b11101???: optab = {1'b0, `CILT_F_NONE, `CILT_B1, `CILT_C1};
        8'hE5: optab = {1'b0, `CILT_F_DIR, `CILT_B2, `CILT_C1};
        8'b1110011?: optab = {1'b0, `CILT_F_IND, `CILT_B1, `CILT_C1};
        8'h74: optab = {1'b0, `CILT_F_IMM, `CILT_B2, `CILT_C1};
        8'b11111???: optab = {1'b0, `CILT_F_NONE, `CILT_B1, `CILT_C1};
        8'b10101???: optab = {1'b0, `CILT_F_DIR, `CILT_B2, `CILT_C2};
        8'b01111???: optab = {1'b0, `CILT_F_IMM, `CILT_B2, `CILT_C1};
        8'hF5: optab = {1'b0, `CILT_F_DIR, `CILT_B2, `CILT_C1};
        8'b10001???: optab = {1'b0, `CILT_F_DIR, `CILT_B2, `CILT_C2};
        8'h85: optab = {1'b0, `CILT_F_DIRDIR, `CILT_B3, `CILT_C2};
        8'b1000011?: optab = {1'b0, `CILT_F_DIR, `CILT_B2, `CILT_C2};
        8'h75: optab = {1'b0, `CILT_F_DIRIMM, `CILT_B3, `CILT_C2};
        8'b1111011?: optab = {1'b0, `CILT_F_IND, `CILT_B1, `CILT_C1};
        8'b1010011?: optab = {1'b0, `CILT_F_DIR, `CILT_B2, `CILT_C2};
        8'b0111011?: optab = {1'b0, `CILT_F_IMM, `CILT_B2, `CILT_C1};
        8'h90: optab = {1'b0, `CILT_F_IMM16, `CILT_B3, `CILT_C2};
        8'h93, 8'h83: optab = {1'b0, `CILT_F_NONE, `CILT_B1, `CILT_C2};
        8'hE0, 8'hF0: optab = {1'b0, `CILT_F_NONE, `CILT_B1, `CILT_C2};
        // register-addressed external forms are flagged, not run
        8'b1110001?, 8'b1111001?: optab = {1'b1, `CILT_F_NONE, `CILT_B1, `CILT_C2};
        8'b11001???: optab = {1'b0, `CILT_F_NONE, `CILT_B1, `CILT_C1};
        8'hC0, 8'hD0: optab = {1'b0, `CILT_F_DIR, `CILT_B2, `CILT_C2};
        8'hC5: optab = {1'b0, `CILT_F_DIR, `CILT_B2, `CILT_C1};
        8'b1100011?, 8'b1101011?: optab = {1'b0, `CILT_F_IND, `CILT_B1, `CILT_C1};
        8'hC3, 8'hD3, 8'hB3: optab = {1'b0, `CILT_F_NONE, `CILT_B1, `CILT_C1};
        8'hC2, 8'hD2, 8'hB2: optab = {1'b0, `CILT_F_BIT, `CILT_B2, `CILT_C1};
        8'h82, 8'hB0, 8'h72, 8'hA0: optab = {1'b0, `CILT_F_BIT, `CILT_B2, `CILT_C2};
        8'hA2: optab = {1'b0, `CILT_F_BIT, `CILT_B2, `CILT_C1};
        8'h92: optab = {1'b0, `CILT_F_BIT, `CILT_B2, `CILT_C2};
        8'h40, 8'h50: optab = {1'b0, `CILT_F_REL, `CILT_B2, `CILT_C2};
        8'h20, 8'h30, 8'h10: optab = {1'b0, `CILT_F_BITREL, `CILT_B3, `CILT_C2};
        8'b???10001: optab = {1'b0, `CILT_F_SHORT, `CILT_B2, `CILT_C2};
        8'h12: optab = {1'b0, `CILT_F_LONG, `CILT_B3, `CILT_C2};
        8'h22, 8'h32: optab = {1'b0, `CILT_F_NONE, `CILT_B1, `CILT_C2};
        8'b???00001: optab = {1'b0, `CILT_F_SHORT, `CILT_B2, `CILT_C2};
        8'h02: optab = {1'b0, `CILT_F_LONG, `CILT_B3, `CILT_C2};
        8'h80, 8'h60, 8'h70: optab = {1'b0, `CILT_F_REL, `CILT_B2, `CILT_C2};
        8'h73: optab = {1'b0, `CILT_F_NONE, `CILT_B1, `CILT_C2};
        8'hB5: optab = {1'b0, `CILT_F_DIRREL, `CILT_B3, `CILT_C2};
        8'hB4, 8'b1011011?, 8'b10111???:
          optab = {1'b0, `CILT_F_IMMREL, `CILT_B3, `CILT_C2};
        8'b11011???: optab = {1'b0, `CILT_F_REL, `CILT_B2, `CILT_C2};
        8'hD5: optab = {1'b0, `CILT_F_DIRREL, `CILT_B3, `CILT_C2};
        // arithmetic and logic groups are decoded elsewhere
        default: optab = {1'b1, `CILT_F_NONE, `CILT_B1, `CILT_C1};
      endcase
    end
  endfunction

  reg [1:0] state_q; // sequencer state
  reg [1:0] state_d;
  reg [7:0] b1_q; // first operand byte
  reg [7:0] b2_q; // second operand byte
  reg [1:0] got_q; // bytes taken so far for this instruction
  reg [1:0] ticks_q; // machine cycles elapsed, saturating
  wire [8:0] ent_new; // table entry of an arriving opcode
  wire [8:0] ent; // table entry of the held opcode
  wire take; // byte accepted this clock
  wire mc_tick; // end of a machine cycle
  wire restart; // restart cycle timer on a new opcode
  wire finish; // all bytes in and all cycles spent
  wire [7:0] bit_src; // byte holding the bit operand
  wire map_sfr;
  wire [7:0] map_bbyte;
  wire [2:0] map_bidx;
  wire map_bok;

  assign take = code_valid & code_ready_q;
  assign ent_new = optab(code_byte);
  assign ent = optab(op_q);
  assign restart = take & (state_q == `CILT_S_IDLE);
  assign finish = (state_q == `CILT_S_EXEC) & (ticks_q >= ent[1:0]);
  assign bit_src = b1_q;

  // machine cycle timer; stall stretches a cycle
  cilt_mcycle #(
    .CLKS(MC_CLKS)
  ) u_mcycle (
    .clk(clk),
    .rst(rst),
    .restart(restart),
    .stretch(stall),
    .tick_q(mc_tick)
  );

  // operand spaces for the held operand bytes
  cilt_opnd_map u_map (
    .dir_opnd(b1_q),
    .bit_opnd(bit_src),
    .dir_is_sfr(map_sfr),
    .bit_byte(map_bbyte),
    .bit_idx(map_bidx),
    .bit_ok(map_bok)
  );

  // next state: gather operand bytes, then wait out the cycles
  always @*
  begin
    state_d = state_q;
    case (state_q)
      `CILT_S_IDLE:
        if (take)
          state_d = (ent_new[3:2] == `CILT_B1) ? `CILT_S_EXEC : `CILT_S_OPND;
      `CILT_S_OPND:
        if (take && (got_q + 2'h1 == ent[3:2]))
          state_d = `CILT_S_EXEC;
      `CILT_S_EXEC:
        if (finish)
          state_d = `CILT_S_IDLE;
      default:
        state_d = `CILT_S_IDLE;
    endcase
  end

  // fetch side: opcode and operand bytes, program counter
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= `CILT_S_IDLE;
      code_ready_q <= 1'b0;
      pc_q <= `CILT_PC_RESET;
      op_q <= 8'h00;
      b1_q <= 8'h00;
      b2_q <= 8'h00;
      got_q <= 2'h0;
      ticks_q <= 2'h0;
    end
    else
    begin
      state_q <= state_d;
      // no bytes taken while an instruction finishes its cycles
      code_ready_q <= (state_d != `CILT_S_EXEC);
      if (pc_load)
        pc_q <= pc_load_val; // core redirects after a taken branch
      else if (take)
        pc_q <= pc_q + 16'h0001;
      if (restart)
      begin
        op_q <= code_byte;
        got_q <= 2'h1;
        ticks_q <= 2'h0;
      end
      else
      begin
        if (take)
        begin
          // operand bytes land in order of arrival
          if (got_q == 2'h1)
            b1_q <= code_byte;
          else
            b2_q <= code_byte;
          got_q <= got_q + 2'h1;
        end
        // saturate: a slow operand fetch only stretches the instruction
        if (mc_tick && ticks_q != 2'h3)
          ticks_q <= ticks_q + 2'h1;
      end
    end
  end

  reg [15:0] tgt_d; // branch or call destination
  reg tk_d; // branch taken
  reg clr_d; // clear tested bit
  reg [7:0] acc_d; // accumulator result
  reg [7:0] mem_d; // operand result to write back
  reg cy_d; // carry result
  reg [7:0] dec_d; // decremented operand
  reg [7:0] cmp_a; // compare left side
  reg [7:0] rel_b; // relative offset byte

  // results and targets of the held instruction
  always @*
  begin
    dec_d = opnd_val - 8'h01;
    // relative byte sits after a bit or direct or immediate operand
    rel_b = (ent[7:4] == `CILT_F_REL) ? b1_q : b2_q;
    tgt_d = pc_q + {{8{rel_b[7]}}, rel_b};
    tk_d = 1'b0;
    clr_d = 1'b0;
    acc_d = acc;
    mem_d = opnd_val;
    cy_d = carry;
    cmp_a = (op_q[3:0] == 4'h4 || op_q == 8'hB5) ? acc : opnd_val;
    case (ent[7:4])
      `CILT_F_SHORT: tgt_d = {pc_q[15:11], op_q[7:5], b1_q};
      `CILT_F_LONG: tgt_d = {b1_q, b2_q};
      default: tgt_d = tgt_d;
    endcase
    casez (op_q)
      8'hC3: cy_d = 1'b0;
      8'hD3: cy_d = 1'b1;
      8'hB3: cy_d = ~carry;
      8'hC2: mem_d = 8'h00;
      8'hD2: mem_d = 8'h01;
      8'hB2: mem_d = {7'h00, ~bit_val};
      8'h82: cy_d = carry & bit_val;
      8'hB0: cy_d = carry & ~bit_val;
      8'h72: cy_d = carry | bit_val;
      8'hA0: cy_d = carry | ~bit_val;
      8'hA2: cy_d = bit_val;
      8'h92: mem_d = {7'h00, carry};
      8'h40: tk_d = carry;
      8'h50: tk_d = ~carry;
      8'h20: tk_d = bit_val;
      8'h30: tk_d = ~bit_val;
      8'h10:
      begin
        tk_d = bit_val;
        clr_d = bit_val; // bit cleared only when the jump goes
      end
      8'h60: tk_d = (acc == 8'h00);
      8'h70: tk_d = (acc != 8'h00);
      8'hB5, 8'hB4, 8'b1011011?, 8'b10111???:
      begin
        // carry reports the unsigned less-than of the compare
        tk_d = (cmp_a != ((op_q == 8'hB5) ? opnd_val : b1_q));
        cy_d = (cmp_a < ((op_q == 8'hB5) ? opnd_val : b1_q));
      end
      8'b11011???, 8'hD5:
      begin
        mem_d = dec_d;
        tk_d = (dec_d != 8'h00);
      end
      8'b1101011?:
      begin
        acc_d = {acc[7:4], opnd_val[3:0]};
        mem_d = {opnd_val[7:4], acc[3:0]};
      end
      8'b11001???, 8'hC5, 8'b1100011?:
      begin
        acc_d = opnd_val;
        mem_d = acc;
      end
      8'hE5, 8'b11101???, 8'b1110011?: acc_d = opnd_val;
      8'h74: acc_d = b1_q;
      8'h73:
      begin
        tk_d = 1'b1;
        tgt_d = data_pointer + {8'h00, acc};
      end
      8'b???10001, 8'h12, 8'b???00001, 8'h02, 8'h80: tk_d = 1'b1;
      default: tk_d = 1'b0;
    endcase
  end

  // publish decode and results once per instruction
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      done_q <= 1'b0;
      len_q <= 2'h0;
      cycles_q <= 2'h0;
      form_q <= `CILT_F_NONE;
      unsup_q <= 1'b0;
      dir_addr_q <= 8'h00;
      dir_is_sfr_q <= 1'b0;
      bit_byte_q <= 8'h00;
      bit_idx_q <= 3'h0;
      bit_ok_q <= 1'b0;
      ind_addr_q <= 8'h00;
      reg_idx_q <= 3'h0;
      target_q <= 16'h0000;
      taken_q <= 1'b0;
      code_addr_q <= 16'h0000;
      clear_bit_q <= 1'b0;
      acc_res_q <= 8'h00;
      mem_res_q <= 8'h00;
      carry_res_q <= 1'b0;
    end
    else
    begin
      done_q <= finish;
      if (finish)
      begin
        len_q <= ent[3:2];
        cycles_q <= ent[1:0];
        form_q <= ent[7:4];
        unsup_q <= ent[8];
        dir_addr_q <= b1_q;
        dir_is_sfr_q <= map_sfr;
        bit_byte_q <= map_bbyte;
        bit_idx_q <= map_bidx;
        bit_ok_q <= map_bok;
        // full eight-bit reach through register zero or one
        ind_addr_q <= op_q[0] ? r1_val : r0_val;
        reg_idx_q <= op_q[2:0];
        target_q <= tgt_d;
        taken_q <= tk_d;
        // table read at accumulator plus pointer or next address
        code_addr_q <= ((op_q == 8'h83) ? pc_q : data_pointer) + {8'h00, acc};
        clear_bit_q <= clr_d;
        acc_res_q <= acc_d;
        mem_res_q <= mem_d;
        carry_res_q <= cy_d;
      end
    end
  end
endmodule // cilt_decoder

//--- src/cilt_mcycle.v
// machine cycle timer with stretch on stall
`timescale 1ns/1ns
`include "cilt_regs.vh"
module cilt_mcycle #(
  parameter CLKS = `CILT_MC_CLKS
) (
  input wire clk,
  input wire rst,
  input wire restart,
  input wire stretch,
  output reg tick_q
);
  localparam [31:0] LAST_W = CLKS - 1; // full-width last count
  localparam [3:0] LAST = LAST_W[3:0]; // cut to the counter width on purpose
  reg [3:0] cnt_q; // core clocks into the current machine cycle

  // count core clocks; a stall freezes the count so the cycle grows
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 4'h0;
      tick_q <= 1'b0;
    end
    else if (restart)
    begin
      cnt_q <= 4'h0;
      tick_q <= 1'b0;
    end
    else if (stretch)
    begin
      tick_q <= 1'b0; // hold: cycle stretched
    end
    else if (cnt_q == LAST)
    begin
      cnt_q <= 4'h0;
      tick_q <= 1'b1; // end of a nominal four-clock cycle
    end
    else
    begin
      cnt_q <= cnt_q + 4'h1;
      tick_q <= 1'b0;
    end
  end
endmodule // cilt_mcycle

//--- src/cilt_opnd_map.v
// operand space mapping for direct and bit operands
`timescale 1ns/1ns
`include "cilt_regs.vh"
module cilt_opnd_map (
  input wire [7:0] dir_opnd,
  input wire [7:0] bit_opnd,
  output wire dir_is_sfr,
  output wire [7:0] bit_byte,
  output wire [2:0] bit_idx,
  output wire bit_ok
);
  // special registers that hold addressable bits
  function sfr_bit_ok;
    input [7:0] base;
    begin
      case (base)
        8'h88, 8'h90, 8'h98, 8'hA8, 8'hB0, 8'hB8,
        8'hC0, 8'hC8, 8'hD0, 8'hD8, 8'hE0, 8'hF0: sfr_bit_ok = 1'b1;
        default: sfr_bit_ok = 1'b0;
      endcase
    end
  endfunction

  // low half is data memory, upper half special registers
  assign dir_is_sfr = (dir_opnd >= `CILT_SFR_BASE);
  // low bit numbers land in the sixteen-byte bit area
  assign bit_byte = bit_opnd[7] ? {bit_opnd[7:3], 3'h0}
                                : (`CILT_BIT_RAM_BASE + {4'h0, bit_opnd[6:3]});
  assign bit_idx = bit_opnd[2:0];
  assign bit_ok = ~bit_opnd[7] | sfr_bit_ok({bit_opnd[7:3], 3'h0});
endmodule // cilt_opnd_map

//--- src/cilt_regs.vh
// constants for the instruction length and timing decoder
`ifndef CILT_REGS_VH
`define CILT_REGS_VH
// core clocks per nominal machine cycle
`define CILT_MC_CLKS 4
// value of the program counter after reset
`define CILT_PC_RESET 16'h0000
// instruction byte lengths
`define CILT_B1 2'h1
`define CILT_B2 2'h2
`define CILT_B3 2'h3
// machine cycle counts
`define CILT_C1 2'h1
`define CILT_C2 2'h2
// operand forms
`define CILT_F_NONE 4'h0
`define CILT_F_DIR 4'h1
`define CILT_F_BIT 4'h2
`define CILT_F_REL 4'h3
`define CILT_F_BITREL 4'h4
`define CILT_F_DIRREL 4'h5
`define CILT_F_IMMREL 4'h6
`define CILT_F_SHORT 4'h7
`define CILT_F_LONG 4'h8
`define CILT_F_DIRDIR 4'h9
`define CILT_F_IMM 4'hA
`define CILT_F_IMM16 4'hB
`define CILT_F_DIRIMM 4'hC
`define CILT_F_IND 4'hD
// direct space split and bit area
`define CILT_SFR_BASE 8'h80
`define CILT_BIT_RAM_BASE 8'h20
// fsm states
`define CILT_S_IDLE 2'h0
`define CILT_S_OPND 2'h1
`define CILT_S_EXEC 2'h2
`endif
